/* File: pkg/pcepin_pkg.sv */
// package: register map, field layout, reset values and timing for the port/chip-enable block
package pcepin_pkg;
    localparam int unsigned ADDR_W         = 4;
    localparam int unsigned DATA_W         = 8;
    // register indices (word addressed on the plain port)
    localparam logic [3:0]  REG_DIR_QUAD   = 4'h0;  // one direction bit per four-pin group
    localparam logic [3:0]  REG_DIR_TRIPLE = 4'h1;
    localparam logic [3:0]  REG_DIR_SER    = 4'h2;  // per-pin, groups one and two
    localparam logic [3:0]  REG_ALT_EN     = 4'h3;
    localparam logic [3:0]  REG_OUT_QUAD   = 4'h4;  // selects group via REG_GRP_SEL
    localparam logic [3:0]  REG_GRP_SEL    = 4'h5;
    localparam logic [3:0]  REG_IN_VIEW    = 4'h6;
    localparam logic [3:0]  REG_OUT_TRIPLE = 4'h7;
    localparam logic [3:0]  REG_OUT_SER    = 4'h8;
    localparam logic [3:0]  REG_CE_DELAY   = 4'h9;
    localparam logic [3:0]  REG_IRQ_STAT   = 4'hA;
    localparam logic [3:0]  REG_IRQ_MASK   = 4'hB;
    localparam logic [3:0]  REG_STATUS     = 4'hC;
    localparam logic [3:0]  REG_VECTOR     = 4'hD;
    // reset values
    localparam logic [7:0]  RST_DIR        = 8'h00;  // zero = input
    localparam logic [7:0]  RST_ALT        = 8'h00;
    localparam logic [7:0]  RST_OUT        = 8'h00;
    localparam logic [7:0]  RST_DELAY      = 8'h00;
    localparam logic [7:0]  RST_MASK       = 8'h00;
    localparam logic [7:0]  ADDR_UNMAPPED  = 8'h00;
    // interrupt status bits
    localparam int unsigned IRQ_CE_FALL    = 0;
    localparam int unsigned IRQ_CE_RESET   = 1;
    // vector address of the chip-enable falling-edge interrupt, highest order
    localparam logic [7:0]  CE_FALL_VECTOR = 8'h0C;
    localparam int unsigned CE_FALL_ORDER  = 1;
    // basic timer setting pulse: 100 Hz at a 40 MHz core clock
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned BT_HZ          = 100;
    localparam int unsigned BT_CYCLES      = CLK_HZ / BT_HZ;
    localparam int unsigned QUAD_GROUPS    = 4;
endpackage

/* File: logic/pcepin_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module pcepin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_d;
            sync_ff <= meta_ff;
        end
    end

    assign o_q = sync_ff;
endmodule
`default_nettype wire

/* File: logic/pcepin_bt_pulse.sv */
// basic timer setting pulse divider: one-cycle enable every period
`timescale 1ns/1ps
`default_nettype none
module pcepin_bt_pulse #(
    parameter int unsigned PERIOD = pcepin_pkg::BT_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_resetn,
    output logic      o_pulse
);
    localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] cnt_ff;
    logic          pulse_ff;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cnt_ff   <= '0;
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= (cnt_ff == LAST);
            cnt_ff   <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
        end
    end

    assign o_pulse = pulse_ff;
endmodule
`default_nettype wire

/* File: logic/pcepin_top.sv */
// general-purpose port groups with chip-enable gating, delayed reset and interrupt
//
// Summary of operation
// R01 - quad groups share one direction bit each
// R02 - three-pin push-pull group, software direction
// R03 - serial shared groups: per-pin direction
// R04 - hard resets make inputs; soft resets retain
// R05 - hard resets return pins to port mode
// R06 - hard resets set quad groups input
// R07 - chip enable high allows synthesizer
// R08 - chip-enable reset waits for timer pulse
// R09 - software delay on chip-enable reset timing
// R10 - chip-enable falling edge raises interrupt
// R11 - clock stop gates port input buffers
// R12 - chip-enable interrupt highest, own vector
// R13 - synchronise chip enable before edge detection
// R14 - directions hold reset default; inputs synchronised
`timescale 1ns/1ps
`default_nettype none
module pcepin_top #(
    parameter int unsigned BT_PERIOD = pcepin_pkg::BT_CYCLES
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_hard_reset,
    input  wire logic       i_clock_stop,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_chip_enable,
    output logic            o_synth_enable,
    output logic            o_ce_reset,
    output logic            o_irq,
    output logic            o_irq_ce_fall,
    output logic      [7:0] o_irq_vector,
    output logic            o_input_gate,
    input  wire logic [15:0] i_quad_pin,
    output logic      [15:0] o_quad_pin,
    output logic      [15:0] o_quad_oe_n,
    input  wire logic [2:0] i_triple_pin,
    output logic      [2:0] o_triple_pin,
    output logic      [2:0] o_triple_oe_n,
    input  wire logic [7:0] i_ser_pin,
    output logic      [7:0] o_ser_pin,
    output logic      [7:0] o_ser_oe_n,
    input  wire logic [7:0] i_ser_alt_out,
    input  wire logic [7:0] i_ser_alt_oe,
    output logic      [7:0] o_alt_enable
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [3:0]  dir_quad_ff;
    logic [2:0]  dir_triple_ff;
    logic [7:0]  dir_ser_ff;
    logic [7:0]  alt_en_ff;
    logic [15:0] out_quad_ff;
    logic [1:0]  grp_sel_ff;
    logic [2:0]  out_triple_ff;
    logic [7:0]  out_ser_ff;
    logic [7:0]  ce_delay_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic [7:0]  rdata_ff;

    logic        hard;

    assign hard = i_hard_reset;

    function automatic logic sel(input logic [3:0] a, input logic [3:0] r, input logic s);
        sel = s && (a == r);
    endfunction

    // R04 hard reset to inputs
    // R06 quad groups to input mode
    // R14 default held until written
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || hard) begin
            dir_quad_ff   <= pcepin_pkg::RST_DIR[3:0];
            dir_triple_ff <= pcepin_pkg::RST_DIR[2:0];
            dir_ser_ff    <= pcepin_pkg::RST_DIR;
        end else begin
            // R01 one bit per group
            if (sel(i_addr, pcepin_pkg::REG_DIR_QUAD, i_wr)) begin
                dir_quad_ff <= i_wdata[3:0];
            end
            // R02 software direction
            if (sel(i_addr, pcepin_pkg::REG_DIR_TRIPLE, i_wr)) begin
                dir_triple_ff <= i_wdata[2:0];
            end
            // R03 per-pin direction
            if (sel(i_addr, pcepin_pkg::REG_DIR_SER, i_wr)) begin
                dir_ser_ff <= i_wdata;
            end
        end
    end

    // R05 back to port mode
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || hard) begin
            alt_en_ff <= pcepin_pkg::RST_ALT;
        end else if (sel(i_addr, pcepin_pkg::REG_ALT_EN, i_wr)) begin
            alt_en_ff <= i_wdata;
        end
    end

    // output latches survive hard reset; inputs mask them anyway
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            out_quad_ff   <= {2{pcepin_pkg::RST_OUT}};
            grp_sel_ff    <= '0;
            out_triple_ff <= pcepin_pkg::RST_OUT[2:0];
            out_ser_ff    <= pcepin_pkg::RST_OUT;
            ce_delay_ff   <= pcepin_pkg::RST_DELAY;
        end else begin
            if (sel(i_addr, pcepin_pkg::REG_GRP_SEL, i_wr)) begin
                grp_sel_ff <= i_wdata[1:0];
            end
            if (sel(i_addr, pcepin_pkg::REG_OUT_QUAD, i_wr)) begin
                out_quad_ff[grp_sel_ff*4 +: 4] <= i_wdata[3:0];
            end
            if (sel(i_addr, pcepin_pkg::REG_OUT_TRIPLE, i_wr)) begin
                out_triple_ff <= i_wdata[2:0];
            end
            if (sel(i_addr, pcepin_pkg::REG_OUT_SER, i_wr)) begin
                out_ser_ff <= i_wdata;
            end
            if (sel(i_addr, pcepin_pkg::REG_CE_DELAY, i_wr)) begin
                ce_delay_ff <= i_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins
    genvar g;
    generate
        for (g = 0; g < pcepin_pkg::QUAD_GROUPS; g++) begin : g_quad
            assign o_quad_pin[g*4 +: 4]  = out_quad_ff[g*4 +: 4];
            assign o_quad_oe_n[g*4 +: 4] = {4{~dir_quad_ff[g]}};
        end
    endgenerate

    assign o_triple_pin  = out_triple_ff;
    assign o_triple_oe_n = ~dir_triple_ff;
    assign o_alt_enable  = alt_en_ff;
    // alternate function takes over the pin driver where enabled
    assign o_ser_pin   = (alt_en_ff & i_ser_alt_out) | (~alt_en_ff & out_ser_ff);
    assign o_ser_oe_n  = ~((alt_en_ff & i_ser_alt_oe) | (~alt_en_ff & dir_ser_ff));

    // R11 input buffers gated in stop
    assign o_input_gate = i_clock_stop;

    logic [26:0] pin_raw;
    logic [26:0] pin_sync;
    assign pin_raw = i_clock_stop ? '0 : {i_ser_pin, i_triple_pin, i_quad_pin};

    // R14 synchronised pin levels
    pcepin_sync #(.W(27)) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_d       (pin_raw),
        .o_q       (pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // chip enable
    logic ce_sync;
    logic ce_prev_ff;
    logic ce_rise;
    logic ce_fall;

    // R13 synchronise before edges
    pcepin_sync #(.W(1)) u_ce_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_d       (i_chip_enable),
        .o_q       (ce_sync)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            ce_prev_ff <= 1'b0;
        end else begin
            ce_prev_ff <= ce_sync;
        end
    end

    assign ce_rise = ce_sync & ~ce_prev_ff;
    assign ce_fall = ~ce_sync & ce_prev_ff;

    // R07 synthesizer follows chip enable
    assign o_synth_enable = ce_sync;

    logic bt_pulse;
    pcepin_bt_pulse #(.PERIOD(BT_PERIOD)) u_bt (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .o_pulse   (bt_pulse)
    );

    // pending reset waits for timer pulses, then counts delay pulses
    typedef enum logic [1:0] {PCEPIN_IDLE, PCEPIN_WAIT, PCEPIN_DELAY} pcepin_ce_e;
    pcepin_ce_e  ce_st_ff;
    logic [7:0]  dly_cnt_ff;
    logic        ce_reset_ff;

    // R08 reset on basic timer pulse
    // R09 delay in timer pulses
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            ce_st_ff    <= PCEPIN_IDLE;
            dly_cnt_ff  <= '0;
            ce_reset_ff <= 1'b0;
        end else begin
            ce_reset_ff <= 1'b0;
            case (ce_st_ff)
                PCEPIN_IDLE: begin
                    if (ce_rise) begin
                        ce_st_ff   <= PCEPIN_WAIT;
                        dly_cnt_ff <= ce_delay_ff;
                    end
                end
                PCEPIN_WAIT, PCEPIN_DELAY: begin
                    if (!ce_sync) begin
                        ce_st_ff <= PCEPIN_IDLE;
                    end else if (bt_pulse) begin
                        if (dly_cnt_ff == '0) begin
                            ce_reset_ff <= 1'b1;
                            ce_st_ff    <= PCEPIN_IDLE;
                        end else begin
                            dly_cnt_ff <= dly_cnt_ff - 1'b1;
                            ce_st_ff   <= PCEPIN_DELAY;
                        end
                    end
                end
                default: ce_st_ff <= PCEPIN_IDLE;
            endcase
        end
    end

    assign o_ce_reset = ce_reset_ff;

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set wins
    logic [1:0] irq_set;
    assign irq_set = {ce_reset_ff, ce_fall};

    // R10 falling edge interrupt
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= pcepin_pkg::RST_MASK[1:0];
        end else begin
            if (sel(i_addr, pcepin_pkg::REG_IRQ_STAT, i_wr)) begin
                irq_stat_ff <= (irq_stat_ff & ~i_wdata[1:0]) | irq_set;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
            if (sel(i_addr, pcepin_pkg::REG_IRQ_MASK, i_wr)) begin
                irq_mask_ff <= i_wdata[1:0];
            end
        end
    end

    assign o_irq = |(irq_stat_ff & irq_mask_ff);
    // R12 highest order, fixed vector
    assign o_irq_ce_fall = irq_stat_ff[pcepin_pkg::IRQ_CE_FALL] &
                           irq_mask_ff[pcepin_pkg::IRQ_CE_FALL];
    assign o_irq_vector  = o_irq_ce_fall ? pcepin_pkg::CE_FALL_VECTOR : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            rdata_ff <= '0;
        end else if (i_rd) begin
            case (i_addr)
                pcepin_pkg::REG_DIR_QUAD:   rdata_ff <= {4'h0, dir_quad_ff};
                pcepin_pkg::REG_DIR_TRIPLE: rdata_ff <= {5'h00, dir_triple_ff};
                pcepin_pkg::REG_DIR_SER:    rdata_ff <= dir_ser_ff;
                pcepin_pkg::REG_ALT_EN:     rdata_ff <= alt_en_ff;
                pcepin_pkg::REG_OUT_QUAD:   rdata_ff <= {4'h0, out_quad_ff[grp_sel_ff*4 +: 4]};
                pcepin_pkg::REG_GRP_SEL:    rdata_ff <= {6'h00, grp_sel_ff};
                // R14 input pins read synchronised level
                pcepin_pkg::REG_IN_VIEW:    rdata_ff <= {4'h0, pin_sync[grp_sel_ff*4 +: 4]};
                pcepin_pkg::REG_OUT_TRIPLE: rdata_ff <= {5'h00, pin_sync[18:16]};
                pcepin_pkg::REG_OUT_SER:    rdata_ff <= pin_sync[26:19];
                pcepin_pkg::REG_CE_DELAY:   rdata_ff <= ce_delay_ff;
                pcepin_pkg::REG_IRQ_STAT:   rdata_ff <= {6'h00, irq_stat_ff};
                pcepin_pkg::REG_IRQ_MASK:   rdata_ff <= {6'h00, irq_mask_ff};
                pcepin_pkg::REG_STATUS:     rdata_ff <= {5'h00, i_clock_stop,
                                                         ce_st_ff != PCEPIN_IDLE, ce_sync};
                pcepin_pkg::REG_VECTOR:     rdata_ff <= pcepin_pkg::CE_FALL_VECTOR;
                default:                    rdata_ff <= pcepin_pkg::ADDR_UNMAPPED;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

/* File: tb/pcepin_properties.sv */
// checker: port-level timing of the port and chip-enable block
`timescale 1ns/1ps
`default_nettype none
module pcepin_properties (
    input wire logic        i_sys_clk,
    input wire logic        i_resetn,
    input wire logic        i_hard_reset,
    input wire logic        i_clock_stop,
    input wire logic        i_rd,
    input wire logic        i_chip_enable,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_synth_enable,
    input wire logic        o_ce_reset,
    input wire logic        o_irq,
    input wire logic        o_irq_ce_fall,
    input wire logic [7:0]  o_irq_vector,
    input wire logic        o_input_gate,
    input wire logic [15:0] o_quad_oe_n,
    input wire logic [2:0]  o_triple_oe_n,
    input wire logic [7:0]  o_ser_oe_n,
    input wire logic [7:0]  o_alt_enable
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // three samples cover the two sync flops; no output register follows them
    sequence s_ce_high;
        i_chip_enable [*3];
    endsequence
    sequence s_ce_low;
        !i_chip_enable [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_gate_follows_stop: assert property (o_input_gate == i_clock_stop)
        else $error("input gate differs from clock stop");
    chk_synth_on_high: assert property (s_ce_high |-> ##1 o_synth_enable)
        else $error("synthesizer not enabled with chip enable high");
    chk_synth_off_low: assert property (s_ce_low |-> ##1 !o_synth_enable)
        else $error("synthesizer not disabled with chip enable low");
    chk_ce_reset_single: assert property (o_ce_reset |=> !o_ce_reset)
        else $error("chip-enable reset longer than one cycle");
    chk_ce_reset_cause: assert property (o_ce_reset |-> $past(o_synth_enable))
        else $error("chip-enable reset without chip enable high");
    chk_vector_value: assert property (o_irq_ce_fall |-> o_irq_vector == 8'h0C && o_irq)
        else $error("chip-enable interrupt vector wrong");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_hard_reset_inputs: assert property (i_hard_reset |=>
        o_quad_oe_n == 16'hFFFF && o_triple_oe_n == 3'h7 && o_ser_oe_n == 8'hFF)
        else $error("hard reset left a pin driving");
    chk_hard_reset_alt: assert property (i_hard_reset |=> o_alt_enable == 8'h00)
        else $error("hard reset left an alternate function on");
    chk_quad_whole_group: assert property ((o_quad_oe_n[3:0] inside {4'h0, 4'hF})
        && (o_quad_oe_n[7:4] inside {4'h0, 4'hF}) && (o_quad_oe_n[11:8] inside {4'h0, 4'hF})
        && (o_quad_oe_n[15:12] inside {4'h0, 4'hF}))
        else $error("quad group pins split in direction");
endmodule
bind pcepin_top pcepin_properties pcepin_properties_inst (
    .i_sys_clk, .i_resetn, .i_hard_reset, .i_clock_stop, .i_rd, .i_chip_enable, .o_rdata,
    .o_synth_enable, .o_ce_reset, .o_irq, .o_irq_ce_fall, .o_irq_vector, .o_input_gate,
    .o_quad_oe_n, .o_triple_oe_n, .o_ser_oe_n, .o_alt_enable
);
`default_nettype wire

/* File: tb/pcepin_board.sv */
// board model: each port pin resolved from device drive and board pull resistors
`timescale 1ns/1ps
`default_nettype none
module pcepin_board (
    input  wire logic [15:0] i_quad_out,
    input  wire logic [15:0] i_quad_oe_n,
    input  wire logic [15:0] i_quad_pull,
    input  wire logic [2:0]  i_tri_out,
    input  wire logic [2:0]  i_tri_oe_n,
    input  wire logic [2:0]  i_tri_pull,
    input  wire logic [7:0]  i_ser_out,
    input  wire logic [7:0]  i_ser_oe_n,
    input  wire logic [7:0]  i_ser_pull,
    output logic      [15:0] o_quad_lvl,
    output logic      [2:0]  o_tri_lvl,
    output logic      [7:0]  o_ser_lvl
);
    // a released pin falls to its resistor, never keeps the last driven value
    assign o_quad_lvl = (i_quad_out & ~i_quad_oe_n) | (i_quad_pull & i_quad_oe_n);
    assign o_tri_lvl  = (i_tri_out & ~i_tri_oe_n) | (i_tri_pull & i_tri_oe_n);
    assign o_ser_lvl  = (i_ser_out & ~i_ser_oe_n) | (i_ser_pull & i_ser_oe_n);
endmodule
`default_nettype wire

/* File: tb/pcepin_top_test.sv */
// testbench: register access, pin directions, resets and chip-enable events
`timescale 1ns/1ps
`default_nettype none
module pcepin_top_test;
    logic        i_sys_clk, i_resetn, i_hard_reset, i_clock_stop, i_wr, i_rd, i_chip_enable;
    logic [3:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, o_irq_vector, o_alt_enable, o_ser_pin, o_ser_oe_n, ser_lvl;
    logic [7:0]  alt_out, alt_oe;
    logic [15:0] o_quad_pin, o_quad_oe_n, quad_lvl;
    logic [2:0]  o_triple_pin, o_triple_oe_n, tri_lvl;
    logic        o_synth_enable, o_ce_reset, o_irq, o_irq_ce_fall, o_input_gate;
    int          fail_count, cmp_count, cyc, n;

    pcepin_top #(.BT_PERIOD(8)) pcepin_top_inst (
        .i_sys_clk, .i_resetn, .i_hard_reset, .i_clock_stop, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_chip_enable, .o_synth_enable, .o_ce_reset, .o_irq, .o_irq_ce_fall,
        .o_irq_vector, .o_input_gate, .i_quad_pin(quad_lvl), .o_quad_pin, .o_quad_oe_n,
        .i_triple_pin(tri_lvl), .o_triple_pin, .o_triple_oe_n, .i_ser_pin(ser_lvl), .o_ser_pin,
        .o_ser_oe_n, .i_ser_alt_out(alt_out), .i_ser_alt_oe(alt_oe), .o_alt_enable
    );
    pcepin_board pcepin_board_inst (
        .i_quad_out(o_quad_pin), .i_quad_oe_n(o_quad_oe_n), .i_quad_pull(16'h3C5A),
        .i_tri_out(o_triple_pin), .i_tri_oe_n(o_triple_oe_n), .i_tri_pull(3'h3),
        .i_ser_out(o_ser_pin), .i_ser_oe_n(o_ser_oe_n), .i_ser_pull(8'h6C),
        .o_quad_lvl(quad_lvl), .o_tri_lvl(tri_lvl), .o_ser_lvl(ser_lvl)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compared %0d mismatched %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        check(what, {8'h00, exp}, {8'h00, o_rdata});
    endtask
    // waits for the chip-enable reset pulse, n = cycles waited, 60 when none came
    task automatic ce_edge(input logic lvl);
        @(posedge i_sys_clk);
        i_chip_enable <= lvl;
        n = 0;
        step(1);
        while (o_ce_reset !== 1'b1 && n < 60) begin
            step(1);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        {i_resetn, i_hard_reset, i_clock_stop, i_wr, i_rd, i_chip_enable} = 6'h00;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        alt_out = 8'h3C;
        alt_oe = 8'hFF;
        {fail_count, cmp_count, cyc, n} = '0;
        repeat (3) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        rd(pcepin_pkg::REG_DIR_QUAD, 8'h00, "dir quad");
        rd(4'hF, 8'h00, "unmapped");
        rd(pcepin_pkg::REG_VECTOR, 8'h0C, "vector");
        check("quad oe", 16'hFFFF, o_quad_oe_n);
        $display("test defaults done");
        wr(pcepin_pkg::REG_DIR_QUAD, 8'h02);
        wr(pcepin_pkg::REG_GRP_SEL, 8'h01);
        wr(pcepin_pkg::REG_OUT_QUAD, 8'h09);
        wr(pcepin_pkg::REG_DIR_TRIPLE, 8'h05);
        wr(pcepin_pkg::REG_OUT_TRIPLE, 8'h06);
        wr(pcepin_pkg::REG_DIR_SER, 8'hA5);
        wr(pcepin_pkg::REG_OUT_SER, 8'hF0);
        step(4);
        check("quad oe", 16'hFF0F, o_quad_oe_n);
        check("quad out", 16'h0009, {12'h000, o_quad_pin[7:4]});
        check("triple oe", 16'h0002, {13'h0, o_triple_oe_n});
        check("ser oe", 16'h005A, {8'h00, o_ser_oe_n});
        check("triple out", 16'h0006, {13'h0, o_triple_pin});
        check("ser out", 16'h00F0, {8'h00, o_ser_pin});
        rd(pcepin_pkg::REG_IN_VIEW, 8'h09, "driven group view");
        rd(pcepin_pkg::REG_OUT_TRIPLE, 8'h06, "triple view");
        wr(pcepin_pkg::REG_ALT_EN, 8'h0F);
        step(1);
        check("alt en", 16'h000F, {8'h00, o_alt_enable});
        check("alt pin", 16'h00FC, {8'h00, o_ser_pin});
        check("alt oe", 16'h0050, {8'h00, o_ser_oe_n});
        @(posedge i_sys_clk);
        alt_oe <= 8'h00;
        step(1);
        check("alt oe off", 16'h005F, {8'h00, o_ser_oe_n});
        $display("test directions done");
        wr(pcepin_pkg::REG_IRQ_MASK, 8'h03);
        ce_edge(1'b1);
        check("ce reset soon", 16'h1, 16'(n >= 3 && n <= 14));
        check("synth on", 16'h1, {15'h0, o_synth_enable});
        check("quad oe kept", 16'hFF0F, o_quad_oe_n);
        check("alt kept", 16'h000F, {8'h00, o_alt_enable});
        step(2);
        rd(pcepin_pkg::REG_IRQ_STAT, 8'h02, "stat reset done");
        check("irq", 16'h1, {15'h0, o_irq});
        wr(pcepin_pkg::REG_IRQ_STAT, 8'h02);
        step(1);
        check("irq cleared", 16'h0, {15'h0, o_irq});
        ce_edge(1'b0);
        check("synth off", 16'h0, {15'h0, o_synth_enable});
        check("ce fall irq", 16'h1, {15'h0, o_irq_ce_fall});
        check("vector", 16'h000C, {8'h00, o_irq_vector});
        wr(pcepin_pkg::REG_IRQ_MASK, 8'h00);
        step(1);
        check("masked irq", 16'h0, {15'h0, o_irq});
        rd(pcepin_pkg::REG_IRQ_STAT, 8'h01, "stat fall");
        wr(pcepin_pkg::REG_IRQ_STAT, 8'h01);
        rd(pcepin_pkg::REG_IRQ_STAT, 8'h00, "stat clear");
        wr(pcepin_pkg::REG_CE_DELAY, 8'h02);
        ce_edge(1'b1);
        check("ce reset delayed", 16'h1, 16'(n >= 17 && n <= 32));
        step(3);
        @(posedge i_sys_clk);
        i_chip_enable <= 1'b0;
        step(6);
        // rise and fall again well before the delayed reset could fire
        @(posedge i_sys_clk);
        i_chip_enable <= 1'b1;
        step(6);
        ce_edge(1'b0);
        check("cancelled reset", 16'd60, 16'(n));
        $display("test chip enable done");
        @(posedge i_sys_clk);
        i_hard_reset <= 1'b1;
        @(posedge i_sys_clk);
        i_hard_reset <= 1'b0;
        step(1);
        check("quad oe hard", 16'hFFFF, o_quad_oe_n);
        check("ser oe hard", 16'h00FF, {8'h00, o_ser_oe_n});
        rd(pcepin_pkg::REG_ALT_EN, 8'h00, "alt hard");
        rd(pcepin_pkg::REG_OUT_TRIPLE, 8'h03, "triple in");
        rd(pcepin_pkg::REG_OUT_SER, 8'h6C, "ser in");
        rd(pcepin_pkg::REG_IN_VIEW, 8'h05, "quad in");
        @(posedge i_sys_clk);
        i_clock_stop <= 1'b1;
        step(4);
        check("input gate", 16'h1, {15'h0, o_input_gate});
        rd(pcepin_pkg::REG_IN_VIEW, 8'h00, "gated view");
        $display("test resets done");
        test_done();
    end
endmodule
`default_nettype wire
